// file: sraux_pkg.sv
// sraux_pkg: shared constants of the sensor result and auxiliary data bank
`default_nettype none

package sraux_pkg;

	localparam int         AXES            = 6;
	localparam int         SLAVES          = 4;
	localparam int         AUX_BYTES       = 24;
	localparam int         SLV_LEN_W       = 4;
	localparam int         DLY_CNT_W       = 5;
	localparam int         SLV_EN_BIT      = 7;
	localparam int         MST_RST_BIT     = 0;
	localparam int         RATE_SENS_FS0   = 131;

	// register indices; byte address is four times the index
	localparam logic [6:0] IDX_SENS_BASE   = 7'h3D;
	localparam logic [6:0] IDX_TEMP_HIGH   = 7'h41;
	localparam logic [6:0] IDX_TEMP_LOW    = 7'h42;
	localparam logic [6:0] IDX_RATE_X_HIGH = 7'h43;
	localparam logic [6:0] IDX_RATE_Z_LOW  = 7'h48;
	localparam logic [6:0] IDX_AUX_FIRST   = 7'h49;
	localparam logic [6:0] IDX_AUX_LAST    = 7'h60;
	localparam logic [6:0] IDX_SLV_CTRL0   = 7'h70;
	localparam logic [6:0] IDX_DLY_EN      = 7'h74;
	localparam logic [6:0] IDX_DLY_CNT     = 7'h75;
	localparam logic [6:0] IDX_MST_RST     = 7'h76;
	localparam logic [6:0] IDX_SENS_EN     = 7'h77;
	localparam logic [6:0] IDX_STATUS      = 7'h78;

	localparam logic [7:0] RST_BYTE        = 8'h00;
	localparam logic [2:0] RST_SENS_EN     = 3'h7;

	typedef enum logic [2:0] {
		SEQ_IDLE  = 3'b001,
		SEQ_ISSUE = 3'b010,
		SEQ_WAIT  = 3'b100
	} sraux_seq_t;

endpackage

`default_nettype wire

// file: sraux_mem.sv
// sraux_mem: aux data byte store with registered read port
`default_nettype none

module sraux_mem #(
	parameter int DEPTH = 24,
	parameter int AW    = 5
) (
	input  wire logic          clk_sys_in,
	input  wire logic          rst_n_in,
	input  wire logic          we_in,
	input  wire logic [AW-1:0] waddr_in,
	input  wire logic [7:0]    wdata_in,
	input  wire logic [AW-1:0] raddr_in,
	output logic      [7:0]    rdata_out
);

	logic [7:0] mem_q [DEPTH];

	// only reset clears bytes; a shrinking allocation leaves them alone
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= 8'h00;
			end
		end else if (we_in && (int'(waddr_in) < DEPTH)) begin
			mem_q[waddr_in] <= wdata_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rdata_out <= 8'h00;
		end else if (int'(raddr_in) < DEPTH) begin
			rdata_out <= mem_q[raddr_in];
		end else begin
			rdata_out <= 8'h00;
		end
	end

endmodule

`default_nettype wire

// file: sraux_bank.sv
// sraux_bank: sensor result registers and aux data store behind wishbone
`default_nettype none

module sraux_bank #(
	parameter int AUX_BYTES = sraux_pkg::AUX_BYTES
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [8:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	input  wire logic        sample_strobe_in,
	input  wire logic [15:0] lin_y_in,
	input  wire logic [15:0] lin_z_in,
	input  wire logic [15:0] temp_in,
	input  wire logic [15:0] rate_x_in,
	input  wire logic [15:0] rate_y_in,
	input  wire logic [15:0] rate_z_in,
	output logic             aux_req_valid_out,
	input  wire logic        aux_req_ready_in,
	output logic      [1:0]  aux_req_slave_out,
	output logic      [3:0]  aux_req_len_out,
	input  wire logic        aux_byte_valid_in,
	input  wire logic [3:0]  aux_byte_idx_in,
	input  wire logic [7:0]  aux_byte_in,
	input  wire logic        aux_done_in,
	input  wire logic        aux_nack_in,
	output logic             aux_master_reset_out
);

	localparam int AXES   = sraux_pkg::AXES;
	localparam int SLAVES = sraux_pkg::SLAVES;

	////////////////////////////////////////////////////////////////////////
	// bus decode

	logic        ack_q;
	logic        req_w;
	logic        wr_w;
	logic        rd_w;
	logic [6:0]  idx_w;
	logic [7:0]  dat_q;
	logic        aux_sel_q;
	logic [7:0]  rd_byte_w;
	logic [7:0]  mem_rd_w;
	logic        is_aux_w;

	assign req_w = wb_cyc_in && wb_stb_in && !ack_q;
	assign idx_w = wb_adr_in[8:2];
	assign wr_w  = wb_cyc_in && wb_stb_in && ack_q && wb_we_in && wb_sel_in[0];
	assign rd_w  = req_w && !wb_we_in;
	assign is_aux_w = (idx_w >= sraux_pkg::IDX_AUX_FIRST) &&
		(idx_w <= sraux_pkg::IDX_AUX_LAST);

	// every access, mapped or not, is acked one cycle after it is seen
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req_w;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			dat_q     <= sraux_pkg::RST_BYTE;
			aux_sel_q <= 1'b0;
		end else if (rd_w) begin
			dat_q     <= rd_byte_w;
			aux_sel_q <= is_aux_w;
		end
	end

	assign wb_ack_out = ack_q;
	assign wb_dat_out = {24'h000000, aux_sel_q ? mem_rd_w : dat_q};

	////////////////////////////////////////////////////////////////////////
	// control registers

	logic [7:0]           slv_ctrl_q [SLAVES];
	logic [SLAVES-1:0]    dly_en_q;
	logic [4:0]           dly_cnt_q;
	logic [2:0]           sens_en_q;
	logic                 mst_rst_q;
	logic [SLAVES-1:0]    en_w;
	logic [3:0]           len_w [SLAVES];

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			for (int s = 0; s < SLAVES; s++) begin
				slv_ctrl_q[s] <= sraux_pkg::RST_BYTE;
			end
			dly_en_q  <= 4'h0;
			dly_cnt_q <= 5'h00;
			sens_en_q <= sraux_pkg::RST_SENS_EN;
		end else if (wr_w) begin
			for (int s = 0; s < SLAVES; s++) begin
				if (idx_w == 7'(int'(sraux_pkg::IDX_SLV_CTRL0) + s)) begin
					slv_ctrl_q[s] <= wb_dat_in[7:0];
				end
			end
			if (idx_w == sraux_pkg::IDX_DLY_EN) begin
				dly_en_q <= wb_dat_in[SLAVES-1:0];
			end
			if (idx_w == sraux_pkg::IDX_DLY_CNT) begin
				dly_cnt_q <= wb_dat_in[4:0];
			end
			if (idx_w == sraux_pkg::IDX_SENS_EN) begin
				sens_en_q <= wb_dat_in[2:0];
			end
		end
	end

	// write-one pulse, gone after one clock
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			mst_rst_q <= 1'b0;
		end else begin
			mst_rst_q <= wr_w && (idx_w == sraux_pkg::IDX_MST_RST) &&
				wb_dat_in[sraux_pkg::MST_RST_BIT];
		end
	end

	assign aux_master_reset_out = mst_rst_q;

	for (genvar s = 0; s < SLAVES; s++) begin : g_ctl
		assign en_w[s]  = slv_ctrl_q[s][sraux_pkg::SLV_EN_BIT];
		assign len_w[s] = slv_ctrl_q[s][3:0];
	end

	////////////////////////////////////////////////////////////////////////
	// sensor results

	logic [15:0]     samp_w [AXES];
	logic [15:0]     sens_q [AXES];
	logic [7:0]      shadow_q [AXES];
	logic            shadow_ok_q [AXES];
	logic [AXES-1:0] axis_en_w;

	assign samp_w[0] = lin_y_in;
	assign samp_w[1] = lin_z_in;
	assign samp_w[2] = temp_in;
	assign samp_w[3] = rate_x_in;
	assign samp_w[4] = rate_y_in;
	assign samp_w[5] = rate_z_in;
	assign axis_en_w = {{3{sens_en_q[2]}}, sens_en_q[1], {2{sens_en_q[0]}}};

	for (genvar k = 0; k < AXES; k++) begin : g_axis
		localparam logic [6:0] HI = 7'(int'(sraux_pkg::IDX_SENS_BASE) + 2 * k);

		always_ff @(posedge clk_sys_in) begin
			if (!rst_n_in || !axis_en_w[k]) begin
				sens_q[k] <= 16'h0000;
			end else if (sample_strobe_in) begin
				sens_q[k] <= samp_w[k];
			end
		end

		// a high read freezes the matching low byte so a burst sees one sample
		always_ff @(posedge clk_sys_in) begin
			if (!rst_n_in) begin
				shadow_q[k]    <= sraux_pkg::RST_BYTE;
				shadow_ok_q[k] <= 1'b0;
			end else if (rd_w && (idx_w == HI)) begin
				shadow_q[k]    <= sens_q[k][7:0];
				shadow_ok_q[k] <= 1'b1;
			end else if (rd_w && (idx_w == HI + 7'h01)) begin
				shadow_ok_q[k] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// allocation of aux bytes

	logic [6:0]        start_q [SLAVES];
	logic [3:0]        alen_q [SLAVES];
	logic [SLAVES-1:0] alloc_q;
	logic [SLAVES-1:0] failed_q;
	logic              stale_q;
	logic [6:0]        top_q;
	logic [6:0]        pre_w [SLAVES];
	logic [6:0]        pre_top_w;
	logic              new_any_w;
	logic [1:0]        new_w;

	always_comb begin
		logic [6:0] acc;
		acc       = 7'h00;
		new_any_w = 1'b0;
		new_w     = 2'h0;
		for (int s = 0; s < SLAVES; s++) begin
			pre_w[s] = acc;
			if (en_w[s]) begin
				acc = acc + 7'(len_w[s]);
			end
		end
		pre_top_w = acc;
		for (int s = SLAVES - 1; s >= 0; s--) begin
			if (en_w[s] && !alloc_q[s]) begin
				new_any_w = 1'b1;
				new_w     = 2'(s);
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			for (int s = 0; s < SLAVES; s++) begin
				start_q[s] <= 7'h00;
				alen_q[s]  <= 4'h0;
			end
			alloc_q <= 4'h0;
			stale_q <= 1'b1;
			top_q   <= 7'h00;
		end else if (mst_rst_q || (en_w == 4'h0)) begin
			alloc_q <= 4'h0;
			stale_q <= 1'b1;
			top_q   <= 7'h00;
		end else if (stale_q) begin
			for (int s = 0; s < SLAVES; s++) begin
				start_q[s] <= pre_w[s];
				alen_q[s]  <= len_w[s];
			end
			alloc_q <= en_w;
			top_q   <= pre_top_w;
			stale_q <= 1'b0;
		end else if (new_any_w) begin
			// a late enable is appended; owned slots never move
			start_q[new_w] <= top_q;
			alen_q[new_w]  <= len_w[new_w];
			alloc_q[new_w] <= 1'b1;
			top_q          <= top_q + 7'(len_w[new_w]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-sample slave sequencing

	sraux_pkg::sraux_seq_t seq_q;
	logic [SLAVES-1:0] pend_q;
	logic [SLAVES-1:0] due_w;
	logic [SLAVES-1:0] clr_w;
	logic [4:0]        dly_phase_q;
	logic [1:0]        low_w;
	logic [1:0]        cur_q;
	logic [3:0]        cur_len_q;
	logic [6:0]        mem_addr_w;
	logic              mem_we_w;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || mst_rst_q) begin
			dly_phase_q <= 5'h00;
		end else if (sample_strobe_in) begin
			dly_phase_q <= (dly_phase_q >= dly_cnt_q) ? 5'h00 : dly_phase_q + 5'h01;
		end
	end

	for (genvar s = 0; s < SLAVES; s++) begin : g_due
		assign due_w[s] = en_w[s] && (len_w[s] != 4'h0) && alloc_q[s] &&
			!failed_q[s] && (!dly_en_q[s] || (dly_phase_q == 5'h00));
	end

	always_comb begin
		low_w = 2'h0;
		for (int s = SLAVES - 1; s >= 0; s--) begin
			if (pend_q[s]) begin
				low_w = 2'(s);
			end
		end
	end

	assign clr_w = (seq_q == sraux_pkg::SEQ_WAIT && (aux_done_in || aux_nack_in)) ?
		(4'h1 << cur_q) : 4'h0;

	// a new sample's request wins over a finishing slave's clear
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || mst_rst_q) begin
			pend_q <= 4'h0;
		end else begin
			pend_q <= (pend_q & ~clr_w) | (sample_strobe_in ? due_w : 4'h0);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || mst_rst_q) begin
			failed_q <= 4'h0;
		end else if (seq_q == sraux_pkg::SEQ_WAIT && aux_nack_in) begin
			failed_q[cur_q] <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || mst_rst_q) begin
			seq_q     <= sraux_pkg::SEQ_IDLE;
			cur_q     <= 2'h0;
			cur_len_q <= 4'h0;
		end else begin
			unique case (seq_q)
				sraux_pkg::SEQ_IDLE: begin
					if (pend_q != 4'h0) begin
						cur_q     <= low_w;
						cur_len_q <= alen_q[low_w];
						seq_q     <= sraux_pkg::SEQ_ISSUE;
					end
				end
				sraux_pkg::SEQ_ISSUE: begin
					if (aux_req_ready_in) begin
						seq_q <= sraux_pkg::SEQ_WAIT;
					end
				end
				sraux_pkg::SEQ_WAIT: begin
					if (aux_done_in || aux_nack_in) begin
						seq_q <= sraux_pkg::SEQ_IDLE;
					end
				end
				default: begin
					seq_q <= sraux_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	assign aux_req_valid_out = (seq_q == sraux_pkg::SEQ_ISSUE);
	assign aux_req_slave_out = cur_q;
	assign aux_req_len_out   = cur_len_q;

	// only slaves 0..3 land here, excess bytes are simply not written
	assign mem_addr_w = start_q[cur_q] + 7'(aux_byte_idx_in);
	assign mem_we_w   = (seq_q == sraux_pkg::SEQ_WAIT) && aux_byte_valid_in &&
		(aux_byte_idx_in < alen_q[cur_q]) && (int'(mem_addr_w) < AUX_BYTES);

	sraux_mem #(
		.DEPTH (AUX_BYTES),
		.AW    (5)
	) u_mem (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.we_in      (mem_we_w),
		.waddr_in   (mem_addr_w[4:0]),
		.wdata_in   (aux_byte_in),
		.raddr_in   (5'(idx_w - sraux_pkg::IDX_AUX_FIRST)),
		.rdata_out  (mem_rd_w)
	);

	////////////////////////////////////////////////////////////////////////
	// read mux

	always_comb begin
		rd_byte_w = 8'h00;
		for (int k = 0; k < AXES; k++) begin
			if (idx_w == 7'(int'(sraux_pkg::IDX_SENS_BASE) + 2 * k)) begin
				rd_byte_w = axis_en_w[k] ? sens_q[k][15:8] : 8'h00;
			end
			if (idx_w == 7'(int'(sraux_pkg::IDX_SENS_BASE) + 2 * k + 1)) begin
				rd_byte_w = !axis_en_w[k] ? 8'h00 :
					(shadow_ok_q[k] ? shadow_q[k] : sens_q[k][7:0]);
			end
		end
		for (int s = 0; s < SLAVES; s++) begin
			if (idx_w == 7'(int'(sraux_pkg::IDX_SLV_CTRL0) + s)) begin
				rd_byte_w = {en_w[s], 3'h0, len_w[s]};
			end
		end
		if (idx_w == sraux_pkg::IDX_DLY_EN) begin
			rd_byte_w = {4'h0, dly_en_q};
		end
		if (idx_w == sraux_pkg::IDX_DLY_CNT) begin
			rd_byte_w = {3'h0, dly_cnt_q};
		end
		if (idx_w == sraux_pkg::IDX_SENS_EN) begin
			rd_byte_w = {5'h00, sens_en_q};
		end
		if (idx_w == sraux_pkg::IDX_STATUS) begin
			rd_byte_w = {alloc_q, failed_q};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	sensor_off_zero_a: assert property (!axis_en_w[0] |=> sens_q[0] == 16'h0000)
		else $error("disabled lin y result not zero");
	lin_z_load_a: assert property ((sample_strobe_in && axis_en_w[1]) |=> sens_q[1] == $past(lin_z_in))
		else $error("lin z sample not loaded");
	temp_load_a: assert property ((sample_strobe_in && axis_en_w[2]) |=> sens_q[2] == $past(temp_in))
		else $error("temperature sample not loaded");
	rate_load_a: assert property ((sample_strobe_in && axis_en_w[5]) |=> sens_q[5] == $past(rate_z_in))
		else $error("rate z sample not loaded");
	burst_shadow_a: assert property ((rd_w && idx_w == sraux_pkg::IDX_RATE_X_HIGH)
		|=> shadow_ok_q[3] && shadow_q[3] == $past(sens_q[3][7:0]))
		else $error("rate x low byte not frozen");
	aux_drop_a: assert property (mem_we_w |-> int'(mem_addr_w) < AUX_BYTES)
		else $error("aux write past last byte");
	aux_owner_a: assert property (mem_we_w |-> alloc_q[cur_q] && aux_byte_idx_in < alen_q[cur_q])
		else $error("aux write outside owner slots");
	slave_order_a: assert property (aux_req_valid_out |-> (pend_q & ((4'h1 << cur_q) - 4'h1)) == 4'h0)
		else $error("lower slave still pending");
	slave_qual_a: assert property ((sample_strobe_in && !en_w[0] && !pend_q[0]) |=> !pend_q[0])
		else $error("disabled slave queued");
	delay_skip_a: assert property ((sample_strobe_in && dly_en_q[1] && dly_phase_q != 5'h00
		&& !pend_q[1]) |=> !pend_q[1])
		else $error("delayed slave read early");
	mst_pulse_a: assert property (aux_master_reset_out |=> !aux_master_reset_out && stale_q)
		else $error("master reset not one cycle");
	realloc_a: assert property (aux_master_reset_out |=> stale_q && alloc_q == 4'h0)
		else $error("reset did not drop allocation");
	alloc_keep_a: assert property ((!stale_q && !mst_rst_q && en_w != 4'h0 && alloc_q[1])
		|=> alloc_q[1] && start_q[1] == $past(start_q[1]))
		else $error("slave 1 slots moved");
	prefix_a: assert property ((stale_q && !mst_rst_q && en_w != 4'h0) |=> start_q[2] == $past(pre_w[2]))
		else $error("slave 2 start not prefix sum");
	bus_ack_a: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");

endmodule

`default_nettype wire

// file: sraux_aux_model.sv
// sraux_aux_model: behavioural aux i2c master with its external sensors
`default_nettype none

module sraux_aux_model (
	input  wire logic       clk_sys_in,
	input  wire logic       rst_n_in,
	input  wire logic       req_valid_in,
	input  wire logic [1:0] req_slave_in,
	input  wire logic [3:0] req_len_in,
	input  wire logic       slow_in,
	input  wire logic [3:0] nack_mask_in,
	input  wire logic [7:0] salt_in,
	output logic            ready_out = 1'b0,
	output logic            byte_valid_out = 1'b0,
	output logic      [3:0] idx_out = 4'h0,
	output logic      [7:0] byte_out = 8'h5A,
	output logic            done_out = 1'b0,
	output logic            nack_out = 1'b0,
	output logic      [7:0] served_out = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] s;
	logic [3:0] n;
	always begin
		@(posedge clk_sys_in);
		if (!rst_n_in) begin
			served_out <= 8'h00;
		end else if (req_valid_in) begin
			// a slow sensor makes the request wait before it is taken
			if (slow_in) repeat (3) @(posedge clk_sys_in);
			ready_out <= 1'b1;
			@(posedge clk_sys_in);
			ready_out <= 1'b0;
			s = req_slave_in;
			n = req_len_in;
			if (!nack_mask_in[s]) begin
				for (int i = 0; i < n; i++) begin
					byte_valid_out <= 1'b1;
					idx_out <= i[3:0];
					byte_out <= salt_in ^ {s, 2'b10, i[3:0]};
					@(posedge clk_sys_in);
					if (slow_in) begin
						byte_valid_out <= 1'b0;
						byte_out <= ~byte_out;
						@(posedge clk_sys_in);
					end
				end
				byte_valid_out <= 1'b0;
				byte_out <= ~byte_out;
			end
			if (nack_mask_in[s]) nack_out <= 1'b1;
			else done_out <= 1'b1;
			@(posedge clk_sys_in);
			done_out <= 1'b0;
			nack_out <= 1'b0;
			served_out <= served_out + 8'h01;
		end else begin
			// idle lines keep moving so stale data is never mistaken for valid
			idx_out <= idx_out + 4'h1;
			byte_out <= ~byte_out;
		end
	end
endmodule

`default_nettype wire

// file: tb.sv
// tb: self-checking bench of the sensor result and aux data bank
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_count++; $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_in = 0, rst_n_in = 0, cyc = 0, stb = 0, we = 0, strobe = 0, slow = 0;
	logic        ready, bv, done, nack, rqv, mrst, ack;
	logic [8:0]  adr = 9'h000;
	logic [3:0]  sel = 4'h0, nmask = 4'h0, rql, bidx;
	logic [31:0] wdat = 32'h0, rdat;
	logic [15:0] sv[6] = '{default: 16'h0000};
	logic [15:0] old;
	logic [1:0]  rqs;
	logic [7:0]  bdat, served, base, salt = 8'h00, q;
	logic [7:0]  exp_aux[24] = '{default: 8'h00};
	int          err_count = 0, n_compared = 0, seed = 73320, cycles = 0, mrst_cnt = 0, m;

	sraux_bank dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .sample_strobe_in(strobe), .lin_y_in(sv[0]), .lin_z_in(sv[1]), .temp_in(sv[2]),
		.rate_x_in(sv[3]), .rate_y_in(sv[4]), .rate_z_in(sv[5]), .aux_req_valid_out(rqv),
		.aux_req_ready_in(ready), .aux_req_slave_out(rqs), .aux_req_len_out(rql), .aux_byte_valid_in(bv),
		.aux_byte_idx_in(bidx), .aux_byte_in(bdat), .aux_done_in(done), .aux_nack_in(nack),
		.aux_master_reset_out(mrst));
	sraux_aux_model sensors (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_valid_in(rqv),
		.req_slave_in(rqs), .req_len_in(rql), .slow_in(slow), .nack_mask_in(nmask), .salt_in(salt),
		.ready_out(ready), .byte_valid_out(bv), .idx_out(bidx), .byte_out(bdat), .done_out(done),
		.nack_out(nack), .served_out(served));

	always #10 clk_sys_in = ~clk_sys_in;

	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		cycles++;
		if (mrst === 1'b1) mrst_cnt++;
		// whole run needs well under this many cycles
		if (cycles == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end

	task automatic bus(input logic w, input logic [6:0] i, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		wdat <= {24'h000000, d};
		sel <= 4'hF;
		@(posedge clk_sys_in);
		while (ack !== 1'b1) begin
			@(posedge clk_sys_in);
		end
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	task automatic chk_rd(input logic [6:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h00);
		`CHK(q, e)
	endtask

	task automatic pulse();
		strobe <= 1'b1;
		@(posedge clk_sys_in);
		strobe <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	// one sample period with fresh sensor data; waits for cnt slave reads
	task automatic round(input int cnt);
		base = served;
		salt <= 8'($random(seed));
		slow <= 1'($random(seed));
		pulse();
		while (8'(served - base) < cnt[7:0]) begin
			@(posedge clk_sys_in);
		end
	endtask

	task automatic set_exp(input logic [1:0] s, input int st, input int len);
		for (int i = 0; i < len; i++) if (st + i < 24) exp_aux[st + i] = salt ^ {s, 2'b10, 4'(i)};
	endtask

	task automatic check_aux();
		for (int j = 0; j < 24; j++) chk_rd(7'(7'h49 + j), exp_aux[j]);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		for (int j = 'h3D; j <= 'h60; j++) chk_rd(7'(j), 8'h00);
		chk_rd(7'h30, 8'h00);
		for (int a = 0; a < 6; a++) begin
			for (int k = 0; k < 6; k++) sv[k] <= 16'($random(seed));
			pulse();
			chk_rd(7'(7'h3D + 2 * a), sv[a][15:8]);
			old = sv[a];
			for (int k = 0; k < 6; k++) sv[k] <= 16'($random(seed));
			pulse();
			chk_rd(7'(7'h3E + 2 * a), old[7:0]);
			chk_rd(7'(7'h3E + 2 * a), sv[a][7:0]);
		end
		bus(1'b1, 7'h41, 8'hFF);
		chk_rd(7'h41, sv[2][15:8]);
		for (int b = 0; b < 3; b++) begin
			bus(1'b1, 7'h77, 8'(3'h7 & ~(3'h1 << b)));
			for (int a = 0; a < 6; a++) begin
				chk_rd(7'(7'h3D + 2 * a), ((a < 2 ? 0 : a == 2 ? 1 : 2) == b) ? 8'h00 : sv[a][15:8]);
				chk_rd(7'(7'h3E + 2 * a), ((a < 2 ? 0 : a == 2 ? 1 : 2) == b) ? 8'h00 : sv[a][7:0]);
			end
			bus(1'b1, 7'h77, 8'h07);
			pulse();
		end
		// slave 2 enabled with zero length must not be read
		bus(1'b1, 7'h70, 8'h84);
		bus(1'b1, 7'h71, 8'h82);
		bus(1'b1, 7'h72, 8'h80);
		bus(1'b1, 7'h73, 8'h83);
		round(3);
		set_exp(2'h0, 0, 4);
		set_exp(2'h1, 4, 2);
		set_exp(2'h3, 6, 3);
		check_aux();
		bus(1'b1, 7'h70, 8'h8F);
		bus(1'b1, 7'h71, 8'h8F);
		bus(1'b1, 7'h73, 8'h03);
		bus(1'b1, 7'h72, 8'h00);
		m = mrst_cnt;
		bus(1'b1, 7'h76, 8'h01);
		repeat (3) @(posedge clk_sys_in);
		`CHK(mrst_cnt - m, 1)
		chk_rd(7'h76, 8'h00);
		round(2);
		set_exp(2'h0, 0, 15);
		set_exp(2'h1, 15, 15);
		check_aux();
		bus(1'b1, 7'h70, 8'h0F);
		round(1);
		set_exp(2'h1, 15, 15);
		check_aux();
		nmask <= 4'h2;
		round(1);
		check_aux();
		chk_rd(7'h78, 8'h32);
		nmask <= 4'h0;
		bus(1'b1, 7'h71, 8'h0F);
		bus(1'b1, 7'h76, 8'h01);
		bus(1'b1, 7'h72, 8'h82);
		round(1);
		set_exp(2'h2, 0, 2);
		check_aux();
		bus(1'b1, 7'h74, 8'h04);
		bus(1'b1, 7'h75, 8'h02);
		base = served;
		// strobe spacing leaves room for the slowest read of two bytes
		repeat (6) begin
			pulse();
			repeat (40) @(posedge clk_sys_in);
		end
		`CHK(8'(served - base), 8'h02)
		tally_and_finish();
	end
endmodule

`default_nettype wire
